// file: common/hpfg_consts.vh
// Register offsets, field positions, reset values and command codes of the host port block.
`ifndef HPFG_CONSTS_VH
`define HPFG_CONSTS_VH

`define HPFG_ADDR_W          16
`define HPFG_OFS_SYSCTRL     16'hFFC4
`define HPFG_OFS_PORT_DATA   16'hFFBB
`define HPFG_OFS_PORT_DIR    16'hFFBD
`define HPFG_OFS_HPCTRL      16'hFFF0
`define HPFG_OFS_DATA1       16'hFFF4
`define HPFG_OFS_STAT1       16'hFFF5
`define HPFG_OFS_DATA2       16'hFFFC
`define HPFG_OFS_STAT2       16'hFFFD

`define HPFG_BIT_HOST_EN     1
`define HPFG_BIT_FG_EN       0
`define HPFG_BIT_GATE        1
`define HPFG_BIT_CMD         3
`define HPFG_BIT_IBF         1
`define HPFG_BIT_OBF         0
`define HPFG_STAT_USER_MASK  8'hF4

`define HPFG_RST_SYSCTRL     8'h00
`define HPFG_RST_HPCTRL      8'h00
`define HPFG_RST_PORT_DATA   8'hFF
`define HPFG_RST_PORT_DIR    8'h00
`define HPFG_RST_STAT        8'h00
`define HPFG_RST_DATA        8'h00
`define HPFG_RST_PINS        13'h1E00

`define HPFG_CMD_GATE        8'hD1
`define HPFG_CMD_NOP         8'hFF

`endif

// file: logic/hpfg_sync.v
// Two-flip-flop synchroniser for the asynchronous host pins.
`timescale 1ns/100ps
module hpfg_sync #(
  parameter W   = 13,
  parameter RST = 13'h1E00
) (
  // Clock and reset
  input  wire         mclk_i,
  input  wire         rstn_i,
  input  wire         ce_i,
  // Data
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// file: logic/hpfg_chan.v
// One host port channel: input and output data registers with their status register.
`timescale 1ns/100ps
`include "hpfg_consts.vh"
module hpfg_chan (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       rstn_i,
  input  wire       ce_i,
  // Host side events
  input  wire       host_wr_i,
  input  wire       host_ibf_i,
  input  wire       host_ha0_i,
  input  wire [7:0] host_din_i,
  input  wire       host_rd_odr_i,
  // Slave side events
  input  wire       slv_rd_idr_i,
  input  wire       slv_wr_odr_i,
  input  wire       slv_wr_stat_i,
  input  wire [7:0] slv_wdata_i,
  // Register contents
  output wire [7:0] idr_o,
  output wire [7:0] odr_o,
  output wire [7:0] stat_o
);

  reg [7:0] idr_q;
  reg [7:0] odr_q;
  reg [7:0] user_q;
  reg       cmd_q;
  reg       ibf_q;
  reg       obf_q;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idr_q  <= `HPFG_RST_DATA;
      odr_q  <= `HPFG_RST_DATA;
      user_q <= `HPFG_RST_STAT;
      cmd_q  <= 1'b0;
      ibf_q  <= 1'b0;
      obf_q  <= 1'b0;
    end else if (ce_i) begin
      if (host_wr_i) begin
        idr_q <= host_din_i;
        cmd_q <= host_ha0_i;
      end
      // Set beats clear so a write landing on the slave's read is not lost.
      if (host_ibf_i)
        ibf_q <= 1'b1;
      else if (slv_rd_idr_i)
        ibf_q <= 1'b0;
      if (slv_wr_odr_i) begin
        odr_q <= slv_wdata_i;
        obf_q <= 1'b1;
      end else if (host_rd_odr_i) begin
        obf_q <= 1'b0;
      end
      if (slv_wr_stat_i)
        user_q <= slv_wdata_i & `HPFG_STAT_USER_MASK;
    end
  end

  assign idr_o  = idr_q;
  assign odr_o  = odr_q;
  assign stat_o = user_q | ({7'h00, cmd_q} << `HPFG_BIT_CMD) | ({7'h00, ibf_q} << `HPFG_BIT_IBF) |
                  ({7'h00, obf_q} << `HPFG_BIT_OBF);

endmodule

// file: logic/hpfg_top.v
// Parallel host port with two register sets and a hardware fast address gate.
`timescale 1ns/100ps
`include "hpfg_consts.vh"
module hpfg_top (
  // Clock, reset and clock enable
  input  wire                    mclk_i,
  input  wire                    rstn_i,
  input  wire                    ce_i,
  // Host pins
  input  wire                    cs1_n_i,
  input  wire                    cs2_n_i,
  input  wire                    ior_n_i,
  input  wire                    iow_n_i,
  input  wire                    ha0_i,
  input  wire [7:0]              hdata_i,
  output reg  [7:0]              hdata_o,
  output reg                     hdata_oe_o,
  // Gate pin
  output reg                     gate_output_pin_o,
  output reg                     gate_oe_o,
  // Input buffer full flags towards the slave CPU
  output reg                     input_full_interrupt_1_o,
  output reg                     input_full_interrupt_2_o,
  // Slave register port
  input  wire [`HPFG_ADDR_W-1:0] addr_i,
  input  wire [7:0]              wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [7:0]              rdata_o
);

  // Synchronised host pins and their values one cycle earlier.
  wire [12:0] pins_s;
  reg  [12:0] pins_p_q;

  wire        s_cs1_n;
  wire        s_cs2_n;
  wire        s_ior_n;
  wire        s_iow_n;
  wire        s_ha0;
  wire        p_cs1_n;
  wire        p_cs2_n;
  wire        p_ior_n;
  wire        p_iow_n;
  wire        p_ha0;
  wire [7:0]  p_data;

  // Slave registers.
  reg  [7:0]  sysctrl_q;
  reg  [7:0]  hpctrl_q;
  reg  [7:0]  port_data_q;
  reg  [7:0]  port_dir_q;
  reg         armed_q;

  // Channel contents.
  wire [7:0]  input_data_reg_1;
  wire [7:0]  output_data_reg_1;
  wire [7:0]  stat1;
  wire [7:0]  input_data_reg_2;
  wire [7:0]  output_data_reg_2;
  wire [7:0]  stat2;

  wire        host_en;
  wire        fg_active;
  wire        iow_rise;
  wire        ior_rise;
  wire        host_wr1;
  wire        host_wr2;
  wire        host_rd_output_data_reg_1;
  wire        host_rd_output_data_reg_2;
  wire        rd_sel1;
  wire        rd_sel2;

  // Fast gate decisions for the current set 1 write.
  reg         fg_quiet;
  reg         fg_gate_wr;
  reg         fg_arm_d;

  // Slave strobe decode.
  wire        slv_wr_sys;
  wire        slv_wr_hp;
  wire        slv_wr_pd;
  wire        slv_wr_pdir;
  wire        slv_wr_d1;
  wire        slv_wr_s1;
  wire        slv_wr_d2;
  wire        slv_wr_s2;
  wire        slv_rd_d1;
  wire        slv_rd_d2;
  reg  [7:0]  rdata_d;
  reg  [7:0]  port_data_d;

  hpfg_sync #(
    .W   (13),
    .RST (`HPFG_RST_PINS)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .async_i ({cs1_n_i, cs2_n_i, ior_n_i, iow_n_i, ha0_i, hdata_i}),
    .sync_o  (pins_s)
  );

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      pins_p_q <= `HPFG_RST_PINS;
    else if (ce_i)
      pins_p_q <= pins_s;
  end

  assign s_cs1_n = pins_s[12];
  assign s_cs2_n = pins_s[11];
  assign s_ior_n = pins_s[10];
  assign s_iow_n = pins_s[9];
  assign s_ha0   = pins_s[8];
  assign p_cs1_n = pins_p_q[12];
  assign p_cs2_n = pins_p_q[11];
  assign p_ior_n = pins_p_q[10];
  assign p_iow_n = pins_p_q[9];
  assign p_ha0   = pins_p_q[8];
  assign p_data  = pins_p_q[7:0];

  assign host_en   = sysctrl_q[`HPFG_BIT_HOST_EN];
  assign fg_active = host_en & hpctrl_q[`HPFG_BIT_FG_EN];

  // A host access is taken at the strobe's rising edge, using the address and data
  // seen while the strobe was still low; the sync delay keeps them aligned.
  assign iow_rise = ~p_iow_n & s_iow_n;
  assign ior_rise = ~p_ior_n & s_ior_n;

  // Both strobes low is a prohibited state and leaves every register untouched.
  assign host_wr1 = host_en & iow_rise & ~p_cs1_n & p_cs2_n & p_ior_n;
  assign host_wr2 = host_en & iow_rise & ~p_cs2_n & p_cs1_n & p_ior_n;
  assign host_rd_output_data_reg_1 = host_en & ior_rise & ~p_cs1_n & p_cs2_n & p_iow_n & ~p_ha0;
  assign host_rd_output_data_reg_2 = host_en & ior_rise & ~p_cs2_n & p_cs1_n & p_iow_n & ~p_ha0;

  assign rd_sel1 = host_en & ~s_cs1_n & s_cs2_n & ~s_ior_n & s_iow_n;
  assign rd_sel2 = host_en & ~s_cs2_n & s_cs1_n & ~s_ior_n & s_iow_n;

  // Fast gate decoder; only set 1 traffic reaches it.
  always @* begin
    fg_quiet   = 1'b0;
    fg_gate_wr = 1'b0;
    fg_arm_d   = armed_q;
    if (!fg_active) begin
      fg_arm_d = 1'b0;
    end else if (host_wr1) begin
      if (p_ha0) begin
        if (p_data == `HPFG_CMD_GATE) begin
          fg_quiet = 1'b1;
          fg_arm_d = 1'b1;
        end else if (p_data == `HPFG_CMD_NOP) begin
          fg_quiet = 1'b1;
          fg_arm_d = 1'b0;
        end else begin
          fg_arm_d = 1'b0;
        end
      end else if (armed_q) begin
        fg_quiet   = 1'b1;
        fg_gate_wr = 1'b1;
        fg_arm_d   = 1'b0;
      end
    end
  end

  // Slave register port decode.
  assign slv_wr_sys  = wr_i & (addr_i == `HPFG_OFS_SYSCTRL);
  assign slv_wr_hp   = wr_i & (addr_i == `HPFG_OFS_HPCTRL);
  assign slv_wr_pd   = wr_i & (addr_i == `HPFG_OFS_PORT_DATA);
  assign slv_wr_pdir = wr_i & (addr_i == `HPFG_OFS_PORT_DIR);
  assign slv_wr_d1   = wr_i & (addr_i == `HPFG_OFS_DATA1);
  assign slv_wr_s1   = wr_i & (addr_i == `HPFG_OFS_STAT1);
  assign slv_wr_d2   = wr_i & (addr_i == `HPFG_OFS_DATA2);
  assign slv_wr_s2   = wr_i & (addr_i == `HPFG_OFS_STAT2);
  assign slv_rd_d1   = rd_i & (addr_i == `HPFG_OFS_DATA1);
  assign slv_rd_d2   = rd_i & (addr_i == `HPFG_OFS_DATA2);

  hpfg_chan u_chan1 (
    .mclk_i        (mclk_i),
    .rstn_i        (rstn_i),
    .ce_i          (ce_i),
    .host_wr_i     (host_wr1),
    .host_ibf_i    (host_wr1 & ~fg_quiet),
    .host_ha0_i    (p_ha0),
    .host_din_i    (p_data),
    .host_rd_odr_i (host_rd_output_data_reg_1),
    .slv_rd_idr_i  (slv_rd_d1),
    .slv_wr_odr_i  (slv_wr_d1),
    .slv_wr_stat_i (slv_wr_s1),
    .slv_wdata_i   (wdata_i),
    .idr_o         (input_data_reg_1),
    .odr_o         (output_data_reg_1),
    .stat_o        (stat1)
  );

  hpfg_chan u_chan2 (
    .mclk_i        (mclk_i),
    .rstn_i        (rstn_i),
    .ce_i          (ce_i),
    .host_wr_i     (host_wr2),
    .host_ibf_i    (host_wr2),
    .host_ha0_i    (p_ha0),
    .host_din_i    (p_data),
    .host_rd_odr_i (host_rd_output_data_reg_2),
    .slv_rd_idr_i  (slv_rd_d2),
    .slv_wr_odr_i  (slv_wr_d2),
    .slv_wr_stat_i (slv_wr_s2),
    .slv_wdata_i   (wdata_i),
    .idr_o         (input_data_reg_2),
    .odr_o         (output_data_reg_2),
    .stat_o        (stat2)
  );

  // The gate shares the port data bit, so its reset value of one is the first gate level.
  // A hardware gate update wins over a slave write in the same cycle.
  always @* begin
    port_data_d = port_data_q;
    if (slv_wr_pd)
      port_data_d = wdata_i;
    if (fg_gate_wr)
      port_data_d[`HPFG_BIT_GATE] = p_data[`HPFG_BIT_GATE];
  end

  always @* begin
    case (addr_i)
      `HPFG_OFS_SYSCTRL:   rdata_d = sysctrl_q;
      `HPFG_OFS_HPCTRL:    rdata_d = hpctrl_q;
      `HPFG_OFS_PORT_DATA: rdata_d = port_data_q;
      `HPFG_OFS_PORT_DIR:  rdata_d = port_dir_q;
      `HPFG_OFS_DATA1:     rdata_d = input_data_reg_1;
      `HPFG_OFS_STAT1:     rdata_d = stat1;
      `HPFG_OFS_DATA2:     rdata_d = input_data_reg_2;
      `HPFG_OFS_STAT2:     rdata_d = stat2;
      default:             rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sysctrl_q   <= `HPFG_RST_SYSCTRL;
      hpctrl_q    <= `HPFG_RST_HPCTRL;
      port_data_q <= `HPFG_RST_PORT_DATA;
      port_dir_q  <= `HPFG_RST_PORT_DIR;
      armed_q     <= 1'b0;
      rdata_o     <= 8'h00;
    end else if (ce_i) begin
      if (slv_wr_sys)
        sysctrl_q <= wdata_i & (8'h01 << `HPFG_BIT_HOST_EN);
      if (slv_wr_hp)
        hpctrl_q <= wdata_i & (8'h01 << `HPFG_BIT_FG_EN);
      if (slv_wr_pdir)
        port_dir_q <= wdata_i;
      port_data_q <= port_data_d;
      armed_q     <= fg_arm_d;
      // Read data stands only in the cycle after the read strobe.
      if (rd_i)
        rdata_o <= rdata_d;
      else
        rdata_o <= 8'h00;
    end
  end

  // Pin outputs, all registered.
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hdata_o                  <= 8'h00;
      hdata_oe_o               <= 1'b0;
      gate_output_pin_o        <= 1'b1;
      gate_oe_o                <= 1'b0;
      input_full_interrupt_1_o <= 1'b0;
      input_full_interrupt_2_o <= 1'b0;
    end else if (ce_i) begin
      hdata_oe_o <= rd_sel1 | rd_sel2;
      if (rd_sel1)
        hdata_o <= s_ha0 ? stat1 : output_data_reg_1;
      else if (rd_sel2)
        hdata_o <= s_ha0 ? stat2 : output_data_reg_2;
      else
        hdata_o <= 8'h00;
      gate_output_pin_o        <= port_data_q[`HPFG_BIT_GATE];
      gate_oe_o                <= port_dir_q[`HPFG_BIT_GATE];
      input_full_interrupt_1_o <= stat1[`HPFG_BIT_IBF];
      input_full_interrupt_2_o <= stat2[`HPFG_BIT_IBF];
    end
  end

endmodule

// file: verification/hpfg_checker_assertions.sv
// Port-level assertions for the host port block.
`timescale 1ns/100ps
`include "hpfg_consts.vh"
module hpfg_checker (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  // Host pins
  input wire logic        ior_n_i,
  input wire logic        iow_n_i,
  input wire logic [7:0]  hdata_o,
  input wire logic        hdata_oe_o,
  // Gate and flags
  input wire logic        gate_output_pin_o,
  input wire logic        gate_oe_o,
  input wire logic        input_full_interrupt_1_o,
  input wire logic        input_full_interrupt_2_o,
  // Slave port
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Host effects land a few cycles after a strobe, so causes are judged by cycles since it.
  logic [3:0] since_iow_q;
  logic [3:0] since_ior_q;
  logic [3:0] since_wr_q;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_iow_q <= 4'hF;
      since_ior_q <= 4'hF;
      since_wr_q  <= 4'hF;
    end else begin
      since_iow_q <= !iow_n_i ? 4'h0 : since_iow_q + {3'h0, since_iow_q != 4'hF};
      since_ior_q <= !ior_n_i ? 4'h0 : since_ior_q + {3'h0, since_ior_q != 4'hF};
      since_wr_q  <= wr_i ? 4'h0 : since_wr_q + {3'h0, since_wr_q != 4'hF};
    end
  end
  a_rdata_pulse: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_quiet_bus: assert property (!hdata_oe_o |-> hdata_o == 8'h00)
    else $error("host data not zero while undriven");
  a_drive_on_read: assert property (hdata_oe_o |-> since_ior_q <= 4'h5)
    else $error("host bus driven without a read");
  a_gate_cause: assert property ($changed(gate_output_pin_o) |-> since_iow_q <= 4'h7 || since_wr_q <= 4'h3)
    else $error("gate moved without a write");
  a_gate_follow: assert property (wr_i && addr_i == `HPFG_OFS_PORT_DATA && since_iow_q >= 4'h8
    |-> ##2 gate_output_pin_o == $past(wdata_i[1], 2))
    else $error("gate does not follow port bit");
  a_oe_cause: assert property ($changed(gate_oe_o) |-> since_wr_q <= 4'h3)
    else $error("gate enable moved without a write");
  a_input_full_interrupt_1_clear: assert property (rd_i && addr_i == `HPFG_OFS_DATA1 && since_iow_q >= 4'h8
    |-> ##3 !input_full_interrupt_1_o)
    else $error("input full 1 not cleared by read");
  a_input_full_interrupt_1_cause: assert property ($rose(input_full_interrupt_1_o) |-> since_iow_q <= 4'h7)
    else $error("input full 1 set without host write");
  a_ibf2_cause: assert property ($rose(input_full_interrupt_2_o) |-> since_iow_q <= 4'h7)
    else $error("input full 2 set without host write");
endmodule

// file: verification/hpfg_host_model.sv
// Behavioural host processor on the parallel host pins.
`timescale 1ns/100ps
module hpfg_host_model (
  // Clock
  input  wire logic       mclk_i,
  // Host bus
  input  wire logic [7:0] hbus_i,
  output logic            cs1_n_o,
  output logic            cs2_n_o,
  output logic            ior_n_o,
  output logic            iow_n_o,
  output logic            ha0_o,
  output logic [7:0]      hdata_o
);
  initial begin
    cs1_n_o = 1'b1;
    cs2_n_o = 1'b1;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    ha0_o   = 1'b0;
    hdata_o = 8'h00;
  end
  // Every phase outlasts the device's synchroniser depth; a faster host could go unseen.
  task automatic xfer(input logic wr, input logic sel2, input logic a0, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk_i);
    cs1_n_o <= sel2;
    cs2_n_o <= !sel2;
    ha0_o   <= a0;
    if (wr) hdata_o <= d;
    repeat (4) @(posedge mclk_i);
    if (wr) iow_n_o <= 1'b0;
    else ior_n_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    q = hbus_i;
    iow_n_o <= 1'b1;
    ior_n_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    cs1_n_o <= 1'b1;
    cs2_n_o <= 1'b1;
    // A released bus shows the inverse so a stale value never passes.
    hdata_o <= ~hdata_o;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// file: verification/hpfg_top_tb.sv
// Self-checking bench for the host port block.
`timescale 1ns/100ps
`include "hpfg_consts.vh"
module hpfg_top_tb;
  logic        mclk_i  = 1'b0;
  logic        rstn_i  = 1'b0;
  logic [15:0] addr_i  = 16'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic        cs1_n, cs2_n, ior_n, iow_n, ha0, dut_oe, gate, gate_oe, irq1, irq2;
  logic [7:0]  host_d, dut_d, rdata_o, q;
  wire  [7:0]  hbus = dut_oe ? dut_d : host_d;
  integer      errors = 0;
  integer      check_count = 0;
  integer      cycles = 0;
  integer      oe_cycles = 0;
  logic [11:0] seq [0:13] = '{12'h746, 12'h000, 12'h7FC, 12'h744, 12'h00A, 12'h4CF, 12'h746,
                              12'h513, 12'h003, 12'h746, 12'h746, 12'h000, 12'hF44, 12'h808};
  always #25 mclk_i = ~mclk_i;
  hpfg_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .cs1_n_i(cs1_n), .cs2_n_i(cs2_n),
    .ior_n_i(ior_n), .iow_n_i(iow_n), .ha0_i(ha0), .hdata_i(hbus), .hdata_o(dut_d), .hdata_oe_o(dut_oe),
    .gate_output_pin_o(gate), .gate_oe_o(gate_oe), .input_full_interrupt_1_o(irq1),
    .input_full_interrupt_2_o(irq2), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  hpfg_host_model host (.mclk_i(mclk_i), .hbus_i(hbus), .cs1_n_o(cs1_n), .cs2_n_o(cs2_n),
    .ior_n_o(ior_n), .iow_n_o(iow_n), .ha0_o(ha0), .hdata_o(host_d));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic swr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic srd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic sck(input logic [15:0] a, input logic [7:0] e, input string w);
    logic [7:0] v;
    srd(a, v);
    chk(v, e, w);
  endtask
  task automatic hwr(input logic sel2, input logic a0, input logic [7:0] d);
    host.xfer(1'b1, sel2, a0, d, q);
  endtask
  task automatic hrd(input logic sel2, input logic a0, input logic [7:0] e, input string w);
    integer n;
    n = oe_cycles;
    host.xfer(1'b0, sel2, a0, 8'h00, q);
    chk(q, e, w);
    // The bus mux falls back to the host's own byte, so the drive enable is checked on its own.
    chk({7'h0, oe_cycles > n}, 8'h01, "host drive");
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  task results;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (dut_oe) oe_cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    settle();
    chk({7'h0, gate}, 8'h01, "gate after reset");
    sck(`HPFG_OFS_SYSCTRL, 8'h00, "sysctrl reset");
    sck(`HPFG_OFS_HPCTRL, 8'h00, "hpctrl reset");
    sck(`HPFG_OFS_PORT_DATA, 8'hFF, "port data reset");
    sck(`HPFG_OFS_PORT_DIR, 8'h00, "port dir reset");
    sck(`HPFG_OFS_STAT1, 8'h00, "stat1 reset");
    sck(16'h0000, 8'h00, "unmapped");
    hwr(1'b0, 1'b0, 8'h55);
    chk({7'h0, irq1}, 8'h00, "input_full_interrupt_1 host off");
    swr(`HPFG_OFS_SYSCTRL, 8'h02);
    swr(`HPFG_OFS_PORT_DIR, 8'h02);
    settle();
    chk({7'h0, gate_oe}, 8'h01, "gate oe");
    hwr(1'b0, 1'b0, 8'h5A);
    chk({7'h0, irq1}, 8'h01, "input_full_interrupt_1 set");
    sck(`HPFG_OFS_STAT1, 8'h02, "stat1 data");
    sck(`HPFG_OFS_DATA1, 8'h5A, "input_data_reg_1 data");
    settle();
    chk({7'h0, irq1}, 8'h00, "input_full_interrupt_1 cleared");
    hwr(1'b0, 1'b1, 8'h33);
    sck(`HPFG_OFS_STAT1, 8'h0A, "stat1 command");
    sck(`HPFG_OFS_DATA1, 8'h33, "input_data_reg_1 command");
    hwr(1'b1, 1'b1, 8'hC3);
    chk({7'h0, irq2}, 8'h01, "ibf2 set");
    sck(`HPFG_OFS_STAT2, 8'h0A, "stat2 command");
    sck(`HPFG_OFS_DATA2, 8'hC3, "input_data_reg_2");
    swr(`HPFG_OFS_DATA1, 8'hA5);
    sck(`HPFG_OFS_STAT1, 8'h09, "stat1 obf");
    hrd(1'b0, 1'b0, 8'hA5, "host output_data_reg_1");
    hrd(1'b0, 1'b1, 8'h08, "host status_reg_1");
    swr(`HPFG_OFS_DATA2, 8'h3C);
    hrd(1'b1, 1'b0, 8'h3C, "host output_data_reg_2");
    hrd(1'b1, 1'b1, 8'h08, "host status_reg_2");
    swr(`HPFG_OFS_PORT_DATA, 8'hFD);
    settle();
    chk({7'h0, gate}, 8'h00, "software gate");
    hwr(1'b0, 1'b1, 8'hD1);
    hwr(1'b0, 1'b0, 8'h02);
    chk({7'h0, gate}, 8'h00, "gate fast off");
    sck(`HPFG_OFS_DATA1, 8'h02, "input_data_reg_1 fast off");
    swr(`HPFG_OFS_PORT_DATA, 8'hFF);
    swr(`HPFG_OFS_HPCTRL, 8'h01);
    for (int i = 0; i < 14; i++) begin
      hwr(seq[i][11], seq[i][10], seq[i][9:2]);
      chk({7'h0, gate}, {7'h0, seq[i][1]}, "fast gate");
      chk({7'h0, irq1}, {7'h0, seq[i][0]}, "input_full_interrupt_1 fast gate");
      if (seq[i][0]) srd(`HPFG_OFS_DATA1, q);
    end
    results();
  end
endmodule
bind hpfg_top hpfg_checker chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .ior_n_i(ior_n_i), .iow_n_i(iow_n_i),
  .hdata_o(hdata_o), .hdata_oe_o(hdata_oe_o), .gate_output_pin_o(gate_output_pin_o), .gate_oe_o(gate_oe_o),
  .input_full_interrupt_1_o(input_full_interrupt_1_o), .input_full_interrupt_2_o(input_full_interrupt_2_o),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
